// >>> core/sarc_pkg.sv
// Purpose: Shared constants and types for the standby and reset control.
// Assumes: 100 MHz core clock; registers reached over AXI4-Lite.
// Notes:   All offsets are byte addresses on a 32-bit data bus.
package sarc_pkg;

   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam logic [ADDR_W-1:0] CLK_OPT_ADDR = 20'h40190;
   localparam logic [ADDR_W-1:0] STBY_STAT_ADDR = 20'h40194;
   localparam logic [ADDR_W-1:0] WAKE_DLY_ADDR = 20'h40198;
   localparam int DEEP_SEL_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Boot and timing
   // ---------------------------------------------------------------
   localparam logic [31:0] BOOT_ADDR = 32'h00c00000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_DLY_NS = 1000;
   // Least time, so round up to whole cycles
   localparam int WAKE_DLY_CYC = (WAKE_DLY_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int DLY_W = 16;

   // ---------------------------------------------------------------
   // Status register field positions
   // ---------------------------------------------------------------
   localparam int STAT_COLD_BIT = 0;
   localparam int STAT_HALT_BIT = 1;
   localparam int STAT_DEEP_BIT = 2;
   localparam int STAT_SLEEP_BIT = 3;
   localparam int STAT_DBG_BIT = 4;
   localparam int STAT_CAUSE_LSB = 8;

   // Wake cause bit order: nmi, external, clock timer, peripheral
   localparam int CAUSE_W = 4;

   typedef enum logic [3:0] {
      ST_RESET, ST_BOOT, ST_RUN, ST_DRAIN, ST_HALT, ST_DHALT,
      ST_SLEEP, ST_WAKEDLY, ST_TRAP
   } sarc_st_t;

   // All state of the controller
   typedef struct packed {
      sarc_st_t st;
      logic [1:0] rst_s;
      logic [1:0] nmi_s;
      logic nmi_prev;
      logic cold;
      logic deep_sel;
      logic to_sleep;
      logic to_deep;
      logic [DLY_W-1:0] dly_cfg;
      logic [DLY_W-1:0] dly_cnt;
      logic [CAUSE_W-1:0] cause;
      logic [31:0] resume_addr;
      logic cpu_run;
      logic init_hold;
      logic cold_init;
      logic boot_req;
      logic psr_clr;
      logic trap_req;
      logic ce_off;
      logic bus_clk_en;
      logic dma_en;
      logic fast_osc_en;
      logic slow_osc_en;
      logic periph_en;
      logic area2_grant;
      logic area2_abort;
      logic aw_got;
      logic w_got;
      logic awready;
      logic wready;
      logic arready;
      logic [ADDR_W-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sarc_state_t;

endpackage

// >>> core/sarc_ctrl.sv
// Purpose: Standby (halt, deep halt, sleep) and initial reset control.
// Assumes: Interrupt requests and CPU strobes share core_clk_in; the
//          reset and nmi pins are asynchronous and synchronised here.
// Notes:   core_clk_in stands for the fast oscillator clock.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module sarc_ctrl
   import sarc_pkg::*;
#(
   parameter logic [DLY_W-1:0] WAKE_DLY_RST = DLY_W'(WAKE_DLY_CYC)
)
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Pins from the board
   input wire logic rst_pin_n_in,
   input wire logic nmi_pin_n_in,
   // CPU side, same clock
   input wire logic halt_exec_in,
   input wire logic sleep_exec_in,
   input wire logic [31:0] next_pc_in,
   input wire logic psr_ie_in,
   input wire logic dbg_mode_in,
   input wire logic bus_busy_in,
   input wire logic area2_req_in,
   // Interrupt requests already level-filtered by the controller
   input wire logic ext_irq_in,
   input wire logic ctimer_irq_in,
   input wire logic periph_irq_in,
   // Control outputs
   output logic cpu_run_out,
   output logic init_hold_out,
   output logic cold_init_out,
   output logic boot_req_out,
   output logic [31:0] boot_addr_out,
   output logic psr_clr_out,
   output logic trap_req_out,
   output logic [31:0] trap_addr_out,
   output logic ce_off_out,
   output logic bus_clk_en_out,
   output logic dma_en_out,
   output logic fast_osc_en_out,
   output logic slow_osc_en_out,
   output logic periph_en_out,
   output logic area2_grant_out,
   output logic area2_abort_out,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ---------------------------------------------------------------
   // State and reset image
   // ---------------------------------------------------------------
   sarc_state_t q;
   sarc_state_t d;
   logic nmi_edge;
   logic mask_ok;
   logic halt_wake;
   logic sleep_wake;
   logic [31:0] stat_word;

   // Pins come up as held in reset with cold start, oscillators on
   localparam sarc_state_t RST_STATE = '{
      st: ST_RESET, nmi_s: 2'h3, nmi_prev: 1'b1, cold: 1'b1,
      dly_cfg: WAKE_DLY_RST, init_hold: 1'b1, cold_init: 1'b1,
      fast_osc_en: 1'b1, slow_osc_en: 1'b1, awready: 1'b1, wready: 1'b1,
      arready: 1'b1, default: '0};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Wake terms; nmi edge uses only the second sync stage
   always_comb
   begin
      nmi_edge = q.nmi_prev & ~q.nmi_s[1];
      mask_ok = psr_ie_in;
      halt_wake = nmi_edge
         | (mask_ok & (ext_irq_in | ctimer_irq_in | periph_irq_in));
      // Fast-clocked peripherals are dead in sleep, so ignored
      sleep_wake = nmi_edge
         | (mask_ok & (ext_irq_in | ctimer_irq_in));
      stat_word = '0;
      stat_word[STAT_COLD_BIT] = q.cold;
      stat_word[STAT_HALT_BIT] = (q.st == ST_HALT) | (q.st == ST_DHALT);
      stat_word[STAT_DEEP_BIT] = q.deep_sel;
      stat_word[STAT_SLEEP_BIT] = (q.st == ST_SLEEP);
      stat_word[STAT_DBG_BIT] = dbg_mode_in;
      stat_word[STAT_CAUSE_LSB +: CAUSE_W] = q.cause;
   end

   // Sequencer, outputs and register slave in one image
   always_comb
   begin
      d = q;
      d.boot_req = 1'b0;
      d.psr_clr = 1'b0;
      d.trap_req = 1'b0;
      d.rst_s = {q.rst_s[0], rst_pin_n_in};
      d.nmi_s = {q.nmi_s[0], nmi_pin_n_in};
      d.nmi_prev = q.nmi_s[1];

      case (q.st)
         ST_RESET:
         begin
            if (q.rst_s[1])
            begin
               d.st = ST_BOOT;
               d.boot_req = 1'b1;
               d.psr_clr = 1'b1;
            end
         end
         ST_BOOT:
         begin
            d.st = ST_RUN;
         end
         ST_RUN:
         begin
            if (halt_exec_in | sleep_exec_in)
            begin
               // Return point kept for the wake trap
               d.resume_addr = next_pc_in;
               d.to_sleep = sleep_exec_in;
               d.to_deep = q.deep_sel;
               d.st = ST_DRAIN;
            end
         end
         ST_DRAIN:
         begin
            // Let the running bus cycle end before stopping
            if (!bus_busy_in)
            begin
               if (q.to_sleep)
                  d.st = ST_SLEEP;
               else if (q.to_deep)
                  d.st = ST_DHALT;
               else
                  d.st = ST_HALT;
            end
         end
         ST_HALT, ST_DHALT:
         begin
            if (halt_wake)
            begin
               d.cause = {periph_irq_in, ctimer_irq_in, ext_irq_in,
                  nmi_edge};
               d.st = ST_TRAP;
            end
         end
         ST_SLEEP:
         begin
            if (sleep_wake)
            begin
               d.cause = {1'b0, ctimer_irq_in, ext_irq_in, nmi_edge};
               if (q.dly_cfg != '0)
               begin
                  d.dly_cnt = q.dly_cfg;
                  d.st = ST_WAKEDLY;
               end
               else
                  d.st = ST_TRAP;
            end
         end
         ST_WAKEDLY:
         begin
            // Oscillator settles while the CPU clock stays gated
            d.dly_cnt = q.dly_cnt - DLY_W'(1);
            if (q.dly_cnt == DLY_W'(1))
               d.st = ST_TRAP;
         end
         ST_TRAP:
         begin
            d.trap_req = 1'b1;
            d.st = ST_RUN;
         end
         default:
         begin
            d.st = ST_RESET;
         end
      endcase

      // Pin reset wins over every state move but not over a trap_req from ST_TRAP; nmi level picks restart kind
      if (!q.rst_s[1])
      begin
         d.st = ST_RESET;
         d.cold = q.nmi_s[1];
      end

      // Output image, registered from the next state
      d.cpu_run = (d.st == ST_RUN) | (d.st == ST_TRAP);
      d.init_hold = (d.st == ST_RESET);
      // Hot start leaves bus and pin registers alone
      d.cold_init = (d.st == ST_RESET) & d.cold;
      d.ce_off = (d.st == ST_HALT) | (d.st == ST_DHALT)
         | (d.st == ST_SLEEP) | (d.st == ST_WAKEDLY);
      // Basic halt keeps bus clock and DMA alive
      d.bus_clk_en = !((d.st == ST_DHALT) | (d.st == ST_SLEEP)
         | (d.st == ST_WAKEDLY));
      d.dma_en = d.bus_clk_en & (d.st != ST_RESET)
         & !dbg_mode_in;
      d.fast_osc_en = (d.st != ST_SLEEP);
      d.slow_osc_en = 1'b1;
      d.periph_en = !((d.st == ST_SLEEP) | (d.st == ST_WAKEDLY)
         | (d.st == ST_RESET)) & !dbg_mode_in;
      // Area two blocked outside debug
      d.area2_grant = area2_req_in & dbg_mode_in;
      d.area2_abort = area2_req_in & !dbg_mode_in;

      // Write channel capture, either order
      if (s_axi_awvalid & !q.aw_got & !q.bvalid)
      begin
         d.aw_got = 1'b1;
         d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & !q.w_got & !q.bvalid)
      begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.aw_got & q.w_got & !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.waddr)
            CLK_OPT_ADDR:
            begin
               if (q.wstrb[0])
                  d.deep_sel = q.wdata[DEEP_SEL_BIT];
            end
            WAKE_DLY_ADDR:
            begin
               if (q.wstrb[0])
                  d.dly_cfg[7:0] = q.wdata[7:0];
               if (q.wstrb[1])
                  d.dly_cfg[15:8] = q.wdata[15:8];
            end
            STBY_STAT_ADDR:
            begin
               d.bresp = RESP_OKAY; // Read-only, write dropped
            end
            default:
            begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end
      else if (q.bvalid & s_axi_bready)
         d.bvalid = 1'b0;

      // Read channel, one outstanding read
      if (s_axi_arvalid & !q.rvalid)
      begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         case (s_axi_araddr)
            CLK_OPT_ADDR:
            begin
               d.rdata = '0;
               d.rdata[DEEP_SEL_BIT] = q.deep_sel;
            end
            STBY_STAT_ADDR:
            begin
               d.rdata = stat_word;
            end
            WAKE_DLY_ADDR:
            begin
               d.rdata = {{(32 - DLY_W){1'b0}}, q.dly_cfg};
            end
            default:
            begin
               d.rdata = '0;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end
      else if (q.rvalid & s_axi_rready)
         d.rvalid = 1'b0;
      // Readies registered so every bus output is a flop
      d.awready = !d.aw_got & !d.bvalid;
      d.wready = !d.w_got & !d.bvalid;
      d.arready = !d.rvalid;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Single flop bank; outputs other than boot_addr_out are plain taps of it
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
         q <= RST_STATE;
      else
         q <= d;
   end

   // Output taps
   assign cpu_run_out = q.cpu_run;
   assign init_hold_out = q.init_hold;
   assign cold_init_out = q.cold_init;
   assign boot_req_out = q.boot_req;
   assign boot_addr_out = BOOT_ADDR;
   assign psr_clr_out = q.psr_clr;
   assign trap_req_out = q.trap_req;
   assign trap_addr_out = q.resume_addr;
   assign ce_off_out = q.ce_off;
   assign bus_clk_en_out = q.bus_clk_en;
   assign dma_en_out = q.dma_en;
   assign fast_osc_en_out = q.fast_osc_en;
   assign slow_osc_en_out = q.slow_osc_en;
   assign periph_en_out = q.periph_en;
   assign area2_grant_out = q.area2_grant;
   assign area2_abort_out = q.area2_abort;
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   boot_clears_psr_a: assert property (
      $rose(q.boot_req) |-> q.psr_clr ##1 (q.cpu_run && !q.psr_clr))
      else $error("boot without status clear");

   restart_kind_a: assert property (
      !q.rst_s[1] |=> q.cold == $past(q.nmi_s[1]))
      else $error("restart kind not taken from nmi level");

   reset_hold_a: assert property (
      !q.rst_s[1] |=> q.init_hold && !q.cpu_run)
      else $error("cpu not held during reset");

   deep_stop_a: assert property (
      (q.st == ST_DHALT || q.st == ST_SLEEP) |->
         !q.bus_clk_en && !q.dma_en && q.ce_off)
      else $error("bus clock or dma alive in deep standby");

   sleep_osc_a: assert property (
      q.st == ST_SLEEP |-> !q.fast_osc_en && q.slow_osc_en
         && !q.periph_en && !q.cpu_run)
      else $error("wrong clocks in sleep");

   drain_wait_a: assert property (
      (q.st == ST_DRAIN && bus_busy_in && q.rst_s[1]) |=>
         q.st == ST_DRAIN && !q.ce_off)
      else $error("standby entered during bus cycle");

   masked_halt_a: assert property (
      (q.st == ST_HALT && !psr_ie_in && !nmi_edge && q.rst_s[1]) |=>
         q.st == ST_HALT)
      else $error("masked interrupt ended halt");

   sleep_periph_a: assert property (
      (q.st == ST_SLEEP && !ext_irq_in && !ctimer_irq_in
         && !nmi_edge && q.rst_s[1]) |=> q.st == ST_SLEEP)
      else $error("sleep ended by peripheral interrupt");

   wake_gate_a: assert property (
      (q.st == ST_SLEEP && sleep_wake && q.rst_s[1]
         && q.dly_cfg == DLY_W'(2)) |=> !q.cpu_run [*2]
         ##1 (q.st == ST_TRAP && q.cpu_run) ##1 q.trap_req)
      else $error("wake delay length wrong");

   area_two_a: assert property (
      q.area2_grant |-> $past(dbg_mode_in) && !q.area2_abort)
      else $error("area two granted outside debug");

   trap_return_a: assert property (
      (q.st == ST_RUN && halt_exec_in && q.rst_s[1]) |=>
         q.resume_addr == $past(next_pc_in))
      else $error("return address not kept");

endmodule

// >>> tb/sarc_board_model.sv
// Purpose: Board reset circuit and interrupt sources for the bench.
// Assumes: Requests arrive from the bench on core_clk_in rising edges.
// Notes:   Irq levels hold until the controller takes its trap.
`timescale 1ns/1ps
module sarc_board_model
#(
   parameter int SETTLE_CYC = 20
)
(
   input wire logic core_clk_in,
   input wire logic pulse_in,
   input wire logic hot_in,
   input wire logic nmi_in,
   input wire logic [2:0] irq_in,
   input wire logic ack_in,
   output logic rst_pin_n_out,
   output logic nmi_pin_n_out,
   output logic [2:0] irq_out
);
   // ---------------------------------------------------------------
   // Reset pin and nmi pin
   // ---------------------------------------------------------------
   // Pin low covers settling plus six clocks; nmi held past release
   initial
   begin
      rst_pin_n_out = 1'b0;
      nmi_pin_n_out = 1'b1;
      repeat (SETTLE_CYC + 6) @(posedge core_clk_in);
      rst_pin_n_out <= 1'b1;
      forever
      begin
         @(posedge core_clk_in);
         if (pulse_in)
         begin
            // Restart kind set with the reset edge, never after it
            rst_pin_n_out <= 1'b0;
            nmi_pin_n_out <= !hot_in;
            repeat (SETTLE_CYC + 6) @(posedge core_clk_in);
            rst_pin_n_out <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            nmi_pin_n_out <= 1'b1;
         end
         else if (nmi_in)
         begin
            nmi_pin_n_out <= 1'b0;
            repeat (4) @(posedge core_clk_in);
            nmi_pin_n_out <= 1'b1;
         end
      end
   end

   // Sources keep asking until served, so a masked one stays pending
   initial irq_out = 3'h0;
   always @(posedge core_clk_in)
      irq_out <= irq_in | (ack_in ? 3'h0 : irq_out);
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the standby and reset control.
// Assumes: Board model drives the pins; bench plays CPU and bus master.
// Notes:   Row codes: kind, source, accept, {wake,bclk,dma,fast osc}.
`timescale 1ns/1ps
module testbench
   import sarc_pkg::*;
();
   logic core_clk_in, reset_in, halt_exec_in, sleep_exec_in, psr_ie_in;
   logic dbg_mode_in, bus_busy_in, area2_req_in, pulse, hot_sel, nmi_req;
   logic [31:0] next_pc_in, boot_addr_out, trap_addr_out, pc, d;
   logic [2:0] irq_req, irq;
   logic rst_pin_n, nmi_pin_n, got;
   logic cpu_run_out, init_hold_out, cold_init_out, boot_req_out;
   logic psr_clr_out, trap_req_out, ce_off_out, bus_clk_en_out;
   logic dma_en_out, periph_en_out, fast_osc_en_out, slow_osc_en_out;
   logic area2_grant_out, area2_abort_out;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] rows [10] = '{16'h001f, 16'h1119, 16'h021f, 16'h0007,
      16'h1309, 16'h2118, 16'h2018, 16'h2210, 16'h2000, 16'h2308};
   int error_cnt = 0;
   int checks_done = 0;
   int cyc_cnt = 0;

   sarc_ctrl #(.WAKE_DLY_RST(16'h0004)) u_sarc_ctrl (.core_clk_in,
      .reset_in, .rst_pin_n_in(rst_pin_n), .nmi_pin_n_in(nmi_pin_n),
      .halt_exec_in, .sleep_exec_in, .next_pc_in, .psr_ie_in, .dbg_mode_in,
      .bus_busy_in, .area2_req_in, .ext_irq_in(irq[0]),
      .ctimer_irq_in(irq[1]), .periph_irq_in(irq[2]), .cpu_run_out,
      .init_hold_out, .cold_init_out, .boot_req_out, .boot_addr_out,
      .psr_clr_out, .trap_req_out, .trap_addr_out, .ce_off_out,
      .bus_clk_en_out, .dma_en_out, .fast_osc_en_out, .slow_osc_en_out,
      .periph_en_out, .area2_grant_out, .area2_abort_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   sarc_board_model u_sarc_board_model (.core_clk_in, .pulse_in(pulse),
      .hot_in(hot_sel), .nmi_in(nmi_req), .irq_in(irq_req),
      .ack_in(trap_req_out), .rst_pin_n_out(rst_pin_n),
      .nmi_pin_n_out(nmi_pin_n), .irq_out(irq));

   // ---------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   // Cuts a hang short; the whole run needs well under this
   always @(posedge core_clk_in)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      @(posedge core_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge core_clk_in);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      chk("bresp", RESP_OKAY, s_axi_bresp);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [ADDR_W-1:0] a);
      @(posedge core_clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge core_clk_in);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Boot pulse must carry the status clear and the fixed vector
   task automatic wait_boot();
      for (int n = 0; n < 200 && boot_req_out !== 1'b1; n++)
         @(negedge core_clk_in);
      chk("boot_req", 1, boot_req_out);
      chk("psr_clr", 1, psr_clr_out);
      chk("boot_addr", 32'h00c00000, boot_addr_out);
      @(negedge core_clk_in);
      chk("cpu_run", 1, cpu_run_out);
   endtask

   task automatic enter(input logic slp);
      @(posedge core_clk_in);
      next_pc_in <= pc;
      halt_exec_in <= !slp;
      sleep_exec_in <= slp;
      @(posedge core_clk_in);
      halt_exec_in <= 1'b0;
      sleep_exec_in <= 1'b0;
   endtask

   // Source 3 is the nmi pin, the rest are irq lines
   task automatic raise(input logic [1:0] s);
      @(posedge core_clk_in);
      if (s == 2'h3)
         nmi_req <= 1'b1;
      else
         irq_req[s] <= 1'b1;
      @(posedge core_clk_in);
      nmi_req <= 1'b0;
      irq_req <= 3'h0;
   endtask

   task automatic wait_trap();
      got = 1'b0;
      repeat (40)
      begin
         @(negedge core_clk_in);
         if (trap_req_out === 1'b1)
         begin
            got = 1'b1;
            chk("trap_addr", pc, trap_addr_out);
            chk("run_at_trap", 1, cpu_run_out);
         end
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {reset_in, halt_exec_in, sleep_exec_in, psr_ie_in} = 4'h8;
      {dbg_mode_in, bus_busy_in, area2_req_in, pulse, hot_sel} = 5'h0;
      {nmi_req, irq_req, next_pc_in, pc} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (4) @(negedge core_clk_in);
      chk("init_hold", 1, init_hold_out);
      chk("cold_init", 1, cold_init_out);
      chk("oscs", 3, {fast_osc_en_out, slow_osc_en_out});
      chk("cpu_run", 0, cpu_run_out);
      repeat (5) @(posedge core_clk_in);
      reset_in <= 1'b0;
      wait_boot();
      axi_rd(WAKE_DLY_ADDR);
      chk("dly_reset", 32'h4, d);
      axi_rd(STBY_STAT_ADDR);
      chk("stat_cold", 1, d[STAT_COLD_BIT]);
      axi_wr(WAKE_DLY_ADDR, 32'h2);
      axi_rd(WAKE_DLY_ADDR);
      chk("dly_rw", 32'h2, d);
      axi_rd(20'h40100);
      chk("unmapped", {30'h0, RESP_SLVERR}, {d[29:0], r});
      $display("test registers done");
      // Table rows: sleep against every wake source, halt and deep halt against two each
      for (int i = 0; i < 10; i++)
      begin
         pc = 32'h00001000 + 32'(i) * 32'h4;
         axi_wr(CLK_OPT_ADDR, {28'h0, rows[i][12], 3'h0});
         axi_rd(CLK_OPT_ADDR);
         chk("deep_sel", rows[i][12], d[DEEP_SEL_BIT]);
         psr_ie_in <= rows[i][4];
         enter(rows[i][13]);
         repeat (4) @(negedge core_clk_in);
         chk("ce_off", 1, ce_off_out);
         chk("cpu_stop", 0, cpu_run_out);
         chk("bus_clk", rows[i][2], bus_clk_en_out);
         chk("dma", rows[i][1], dma_en_out);
         chk("fast_osc", rows[i][0], fast_osc_en_out);
         chk("slow_osc", 1, slow_osc_en_out);
         chk("periph", !rows[i][13], periph_en_out);
         axi_rd(STBY_STAT_ADDR);
         chk("stat_mode", {rows[i][13], rows[i][12], !rows[i][13]},
            d[STAT_SLEEP_BIT:STAT_HALT_BIT]);
         raise(rows[i][9:8]);
         wait_trap();
         chk("wake", rows[i][3], got);
         axi_rd(STBY_STAT_ADDR);
         if (got)
            chk("cause", rows[i][9:8] == 2'h3 ? 32'h1 : 32'h2
               << rows[i][9:8], d[STAT_CAUSE_LSB +: CAUSE_W]);
         if (!got)
         begin
            raise(2'h3);
            wait_trap();
            chk("nmi_wake", 1, got);
         end
      end
      $display("test standby rows done");
      // Entry while a bus cycle is still running
      pc = 32'h00002000;
      @(posedge core_clk_in);
      bus_busy_in <= 1'b1;
      psr_ie_in <= 1'b1;
      enter(1'b0);
      repeat (5) @(negedge core_clk_in);
      chk("ce_busy", 0, ce_off_out);
      @(posedge core_clk_in);
      bus_busy_in <= 1'b0;
      repeat (3) @(negedge core_clk_in);
      chk("ce_after", 1, ce_off_out);
      raise(2'h0);
      wait_trap();
      chk("busy_wake", 1, got);
      $display("test bus drain done");
      // Area two outside and inside debug mode
      @(posedge core_clk_in);
      area2_req_in <= 1'b1;
      repeat (2) @(negedge core_clk_in);
      chk("a2_out", 2'h1, {area2_grant_out, area2_abort_out});
      @(posedge core_clk_in);
      dbg_mode_in <= 1'b1;
      repeat (2) @(negedge core_clk_in);
      chk("a2_in", 2'h2, {area2_grant_out, area2_abort_out});
      chk("dbg_en", 4'h9, {fast_osc_en_out, periph_en_out, dma_en_out,
         cpu_run_out});
      @(posedge core_clk_in);
      dbg_mode_in <= 1'b0;
      area2_req_in <= 1'b0;
      $display("test debug done");
      // Hot then cold pin reset in mid-run
      for (int k = 0; k < 2; k++)
      begin
         @(posedge core_clk_in);
         hot_sel <= (k == 0);
         pulse <= 1'b1;
         @(posedge core_clk_in);
         pulse <= 1'b0;
         repeat (12) @(negedge core_clk_in);
         chk("pin_hold", 1, init_hold_out);
         chk("pin_cold", k, cold_init_out);
         chk("pin_run", 0, cpu_run_out);
         chk("pin_osc", 1, fast_osc_en_out);
         wait_boot();
         axi_rd(STBY_STAT_ADDR);
         chk("stat_kind", k, d[STAT_COLD_BIT]);
      end
      $display("test pin reset done");
      complete_run();
   end
endmodule
